// >>> core/sdc_pkg.sv
`default_nettype none
package sdc_pkg;
	// descriptor record and selector layout
	localparam int SDC_DESC_BYTES = 8;
	localparam int SEL_TABLE_BIT = 2;
	localparam int SEL_IDX_LSB = 3;
	localparam int AR_P = 7;
	localparam int AR_PRIV_HI = 6;
	localparam int AR_PRIV_LO = 5;
	localparam int AR_S = 4;
	localparam int AR_E = 3;
	localparam int AR_EC = 2;
	localparam int AR_WR = 1;
	localparam int AR_A = 0;
	localparam int AR_TYPE_HI = 2;
	localparam int WORD_HI_LSB = 8;
	// system descriptor types
	localparam logic [2:0] SYS_TASK_FREE = 3'h1;
	localparam logic [2:0] SYS_LOCAL_TABLE = 3'h2;
	localparam logic [2:0] SYS_TASK_BUSY = 3'h3;
	// exception vectors
	localparam logic [7:0] EXC_GP = 8'h0D;
	localparam logic [7:0] EXC_NP = 8'h0B;
	// word positions inside the 8-byte record
	localparam logic [1:0] WORD_LIMIT = 2'h0;
	localparam logic [1:0] WORD_BASE_LO = 2'h1;
	localparam logic [1:0] WORD_BASE_HI = 2'h2;
	localparam logic [1:0] WORD_LAST = 2'h3;
	localparam logic [23:0] WORD_STEP = 24'h000002;
	localparam logic [16:0] DESC_LAST_BYTE = 17'h00007;
	localparam logic [2:0] SEL_IDX_ZERO = 3'h0;
	localparam int SEG_COUNT = 4;

	typedef struct packed {
		logic [7:0] access;
		logic [23:0] base;
		logic [15:0] limit;
	} sdc_desc_t;

	typedef struct packed {
		logic present;
		logic [1:0] descriptor_priv_level;
		logic isSeg;
		logic isCode;
		logic expand_direction;
		logic writable;
		logic conforming;
		logic readable;
		logic isTaskSeg;
		logic isLocalTable;
		logic privChecked;
	} sdc_attr_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_CHECK = 2'b10,
		ST_MARK = 2'b11
	} sdc_state_t;
endpackage
`default_nettype wire

// >>> core/sdc_attr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_attr_decode
	import sdc_pkg::*;
(
	input wire logic [7:0] access,
	output sdc_attr_t attr
);
	logic [2:0] sysType;
	assign sysType = access[AR_TYPE_HI:AR_A];
	// access-rights byte fields
	always_comb begin
		attr.present = access[AR_P];
		attr.descriptor_priv_level = access[AR_PRIV_HI:AR_PRIV_LO];
		attr.isSeg = access[AR_S];
		attr.isCode = access[AR_S] & access[AR_E];
		attr.expand_direction = access[AR_EC] & ~access[AR_E];
		attr.writable = access[AR_WR] & ~access[AR_E];
		attr.conforming = access[AR_EC] & access[AR_E];
		attr.readable = ~access[AR_E] | access[AR_WR];
		attr.isTaskSeg = ~access[AR_S] & (sysType == SYS_TASK_FREE || sysType == SYS_TASK_BUSY);
		attr.isLocalTable = ~access[AR_S] & (sysType == SYS_LOCAL_TABLE);
		attr.privChecked = access[AR_S] | attr.isTaskSeg;
	end
endmodule
`default_nettype wire

// >>> core/sdc_cache_slot.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_cache_slot
	import sdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wrEn,
	input wire sdc_desc_t wrDesc,
	output sdc_desc_t desc,
	output logic loaded
);
	// hidden descriptor copy, cleared by reset, otherwise changes only on a reload of its register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			desc <= '0;
			loaded <= 1'b0;
		end else if (wrEn) begin
			desc <= wrDesc;
			loaded <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> core/sdc_check.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_check
	import sdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic loadReq,
	input wire logic [1:0] loadSeg,
	input wire logic [15:0] loadSel,
	input wire logic [23:0] globalTableBase,
	input wire logic [15:0] globalTableLimit,
	input wire logic [23:0] localTableBase,
	input wire logic [15:0] localTableLimit,
	output logic loadBusy,
	output logic loadDone,
	output logic loadFault,
	output logic [7:0] loadVector,
	output logic [15:0] loadedSel,
	output logic [1:0] loadedSeg,
	output logic busReq,
	output logic busWrite,
	output logic busLock,
	output logic [23:0] busAddr,
	output logic [15:0] busWData,
	input wire logic [15:0] busRData,
	input wire logic busAck,
	input wire logic accReq,
	input wire logic [1:0] accSeg,
	input wire logic [15:0] accOffset,
	input wire logic accWrite,
	input wire logic accExec,
	input wire logic [1:0] current_priv_level,
	output logic accDone,
	output logic accFault,
	output logic [7:0] accVector,
	output logic [23:0] physAddr
);
	sdc_state_t state_reg;
	logic [1:0] wordCnt_reg;
	logic [1:0] seg_reg;
	logic [15:0] sel_reg;
	logic [23:0] descAddr_reg;
	sdc_desc_t fetch_reg;
	sdc_attr_t fetchAttr;
	sdc_attr_t useAttr;
	sdc_desc_t slotDesc [SEG_COUNT];
	logic slotLoaded [SEG_COUNT];
	logic [SEG_COUNT-1:0] slotWe;
	sdc_desc_t useDesc;
	logic useLoaded;
	logic selLocal;
	logic [23:0] tblBase;
	logic [15:0] tblLimit;
	logic [15:0] selOffset;
	logic overLimit;
	logic commit;
	logic inLimit;
	logic rightsOk;
	logic [23:0] sumAddr;

	// selector split and table bounds check
	assign selLocal = loadSel[SEL_TABLE_BIT];
	assign selOffset = {loadSel[15:SEL_IDX_LSB], SEL_IDX_ZERO};
	assign tblBase = selLocal ? localTableBase : globalTableBase;
	assign tblLimit = selLocal ? localTableLimit : globalTableLimit;
	assign overLimit = ({1'b0, selOffset} + DESC_LAST_BYTE) > {1'b0, tblLimit};
	assign commit = (state_reg == ST_MARK) && busAck;

	sdc_attr_decode u_fetchDecode (
		.access(fetch_reg.access),
		.attr(fetchAttr)
	);

	// one hidden cache slot per segment register
	genvar g;
	generate
		for (g = 0; g < SEG_COUNT; g++) begin : gSlot
			assign slotWe[g] = commit && (seg_reg == 2'(g));
			sdc_cache_slot u_slot (
				.ref_clk(ref_clk),
				.reset(reset),
				.wrEn(slotWe[g]),
				.wrDesc(fetch_reg),
				.desc(slotDesc[g]),
				.loaded(slotLoaded[g])
			);
		end
	endgenerate

	// load sequencer: bounds, locked fetch, check, accessed-bit write
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			wordCnt_reg <= WORD_LIMIT;
			seg_reg <= 2'h0;
			sel_reg <= 16'h0000;
			descAddr_reg <= 24'h000000;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (loadReq && !overLimit) begin
						state_reg <= ST_FETCH;
						wordCnt_reg <= WORD_LIMIT;
						seg_reg <= loadSeg;
						sel_reg <= loadSel;
						descAddr_reg <= tblBase + {8'h00, selOffset};
					end
				end
				ST_FETCH: begin
					if (busAck) begin
						wordCnt_reg <= wordCnt_reg + 2'h1;
						if (wordCnt_reg == WORD_LAST) begin
							state_reg <= ST_CHECK;
						end
					end
				end
				ST_CHECK: begin
					if (fetchAttr.present && fetchAttr.isSeg) begin
						state_reg <= ST_MARK;
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				ST_MARK: begin
					if (busAck) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// gather the descriptor words
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			fetch_reg <= '0;
		end else if (state_reg == ST_FETCH && busAck) begin
			unique case (wordCnt_reg)
				WORD_LIMIT: fetch_reg.limit <= busRData;
				WORD_BASE_LO: fetch_reg.base[15:0] <= busRData;
				WORD_BASE_HI: begin
					fetch_reg.base[23:16] <= busRData[WORD_HI_LSB-1:0];
					fetch_reg.access <= busRData[15:WORD_HI_LSB];
				end
				WORD_LAST: ; // reserved word, read to complete the record
			endcase
		end
	end

	// bus master signals, lock spans fetch and update
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busReq <= 1'b0;
			busWrite <= 1'b0;
			busLock <= 1'b0;
			busAddr <= 24'h000000;
			busWData <= 16'h0000;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (loadReq && !overLimit) begin
						busReq <= 1'b1;
						busLock <= 1'b1;
						busWrite <= 1'b0;
						busAddr <= tblBase + {8'h00, selOffset};
					end
				end
				ST_FETCH: begin
					if (busAck) begin
						busAddr <= busAddr + WORD_STEP;
						if (wordCnt_reg == WORD_LAST) begin
							busReq <= 1'b0;
						end
					end
				end
				ST_CHECK: begin
					if (fetchAttr.present && fetchAttr.isSeg) begin
						busReq <= 1'b1;
						busWrite <= 1'b1;
						busAddr <= descAddr_reg + WORD_STEP + WORD_STEP;
						busWData <= {fetch_reg.access | 8'h01, fetch_reg.base[23:16]};
					end else begin
						busLock <= 1'b0;
					end
				end
				ST_MARK: begin
					if (busAck) begin
						busReq <= 1'b0;
						busWrite <= 1'b0;
						busLock <= 1'b0;
					end
				end
			endcase
		end
	end

	// load status towards the segment register file
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			loadBusy <= 1'b0;
			loadDone <= 1'b0;
			loadFault <= 1'b0;
			loadVector <= 8'h00;
			loadedSel <= 16'h0000;
			loadedSeg <= 2'h0;
		end else begin
			loadDone <= commit;
			loadFault <= 1'b0;
			loadBusy <= (state_reg == ST_IDLE) ? (loadReq && !overLimit) : !commit &&
				!(state_reg == ST_CHECK && !(fetchAttr.present && fetchAttr.isSeg));
			if (commit) begin
				loadedSel <= sel_reg;
				loadedSeg <= seg_reg;
			end
			if (state_reg == ST_IDLE && loadReq && overLimit) begin
				loadFault <= 1'b1;
				loadVector <= EXC_GP;
			end else if (state_reg == ST_CHECK && !fetchAttr.present) begin
				loadFault <= 1'b1;
				loadVector <= EXC_NP;
			end else if (state_reg == ST_CHECK && !fetchAttr.isSeg) begin
				loadFault <= 1'b1;
				loadVector <= EXC_GP;
			end
		end
	end

	// access check against the cached descriptor
	assign useDesc = slotDesc[accSeg];
	assign useLoaded = slotLoaded[accSeg];
	sdc_attr_decode u_useDecode (
		.access(useDesc.access),
		.attr(useAttr)
	);
	assign sumAddr = useDesc.base + {8'h00, accOffset};
	assign inLimit = useAttr.expand_direction ? (accOffset > useDesc.limit) :
		(accOffset <= useDesc.limit);
	always_comb begin
		rightsOk = 1'b1;
		if (accWrite && (useAttr.isCode || !useAttr.writable)) begin
			rightsOk = 1'b0;
		end
		if (!accWrite && !accExec && !useAttr.readable) begin
			rightsOk = 1'b0;
		end
		if (accExec && (!useAttr.isCode || (useAttr.conforming && useAttr.privChecked &&
			current_priv_level < useAttr.descriptor_priv_level))) begin
			rightsOk = 1'b0;
		end
	end

	// registered answer; a fault holds the address at its old value
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			accDone <= 1'b0;
			accFault <= 1'b0;
			accVector <= 8'h00;
			physAddr <= 24'h000000;
		end else begin
			accDone <= accReq;
			accFault <= 1'b0;
			if (accReq) begin
				if (!useLoaded || !useAttr.present) begin
					accFault <= 1'b1;
					accVector <= EXC_NP;
				end else if (!inLimit || !rightsOk) begin
					accFault <= 1'b1;
					accVector <= EXC_GP;
				end else begin
					physAddr <= sumAddr;
				end
			end
		end
	end

	property p_lock_held;
		@(posedge ref_clk) disable iff (reset) busReq |-> busLock;
	endproperty
	a_lock_held: assert property (p_lock_held) else $error("bus request without lock");
	property p_req_hold;
		@(posedge ref_clk) disable iff (reset) busReq && !busAck |=> busReq && $stable(busAddr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
	property p_four_words;
		@(posedge ref_clk) disable iff (reset)
			state_reg == ST_FETCH && busAck && wordCnt_reg == WORD_LAST |=> state_reg == ST_CHECK && !busReq;
	endproperty
	a_four_words: assert property (p_four_words) else $error("record not closed after fourth word");
	property p_mark_set;
		@(posedge ref_clk) disable iff (reset) busReq && busWrite |-> busWData[WORD_HI_LSB + AR_A];
	endproperty
	a_mark_set: assert property (p_mark_set) else $error("accessed bit not set in write");
	property p_np_fault;
		@(posedge ref_clk) disable iff (reset)
			state_reg == ST_CHECK && !fetchAttr.present |=> loadFault && loadVector == EXC_NP && !busLock;
	endproperty
	a_np_fault: assert property (p_np_fault) else $error("missing not-present fault");
	property p_table_limit;
		@(posedge ref_clk) disable iff (reset)
			state_reg == ST_IDLE && loadReq && overLimit |=> loadFault && loadVector == EXC_GP && !busReq;
	endproperty
	a_table_limit: assert property (p_table_limit) else $error("table limit not enforced");
	property p_no_cache_on_fault;
		@(posedge ref_clk) disable iff (reset) loadFault |-> $stable(loadedSel) && !loadDone;
	endproperty
	a_no_cache_on_fault: assert property (p_no_cache_on_fault) else $error("state changed on failed load");
	property p_addr_sum;
		@(posedge ref_clk) disable iff (reset)
			accReq && useLoaded && useAttr.present && inLimit && rightsOk |=> !accFault && physAddr == $past(sumAddr);
	endproperty
	a_addr_sum: assert property (p_addr_sum) else $error("wrong physical address");
	property p_code_write;
		@(posedge ref_clk) disable iff (reset)
			accReq && accWrite && useAttr.isCode |=> accFault && $stable(physAddr);
	endproperty
	a_code_write: assert property (p_code_write) else $error("code write not refused");
	property p_expand_down;
		@(posedge ref_clk) disable iff (reset)
			accReq && useLoaded && useAttr.present && useAttr.expand_direction && accOffset <= useDesc.limit
			|=> accFault;
	endproperty
	a_expand_down: assert property (p_expand_down) else $error("expand-down limit not enforced");
	c_load_done: cover property (@(posedge ref_clk) disable iff (reset) loadDone);
	c_load_np: cover property (@(posedge ref_clk) disable iff (reset) loadFault && loadVector == EXC_NP);
	c_acc_ok: cover property (@(posedge ref_clk) disable iff (reset) accDone && !accFault);
endmodule
`default_nettype wire

// >>> testbench/sdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_mem_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic busReq,
	input wire logic busWrite,
	input wire logic busLock,
	input wire logic [23:0] busAddr,
	input wire logic [15:0] busWData,
	output logic [15:0] busRData,
	output logic busAck
);
	logic [15:0] mem [0:255];
	int waitCnt = 0;
	int ackCnt = 0;
	int lockMiss = 0;
	// one word per request, answered at once or after three idle cycles
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busAck <= 1'b0;
			busRData <= 16'hA5A5;
			waitCnt <= 0;
		end else if (busAck || !busReq) begin
			busAck <= 1'b0;
			busRData <= ~busRData; // released data never looks valid
			waitCnt <= slow ? 3 : 0;
		end else if (waitCnt != 0) begin
			waitCnt <= waitCnt - 1;
		end else begin
			busAck <= 1'b1;
			busRData <= mem[busAddr[8:1]];
			if (busWrite)
				mem[busAddr[8:1]] <= busWData;
			ackCnt <= ackCnt + 1;
			if (!busLock)
				lockMiss <= lockMiss + 1;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sdc_pkg::*;
	localparam logic [23:0] GBASE = 24'h000040;
	localparam logic [23:0] LBASE = 24'h000080;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic loadReq = 1'b0;
	logic [1:0] loadSeg = 2'h0;
	logic [15:0] loadSel = 16'h0000;
	logic accReq = 1'b0;
	logic [1:0] accSeg = 2'h0;
	logic [15:0] accOffset = 16'h0000;
	logic accWrite = 1'b0;
	logic accExec = 1'b0;
	logic [1:0] curLevel = 2'h0;
	logic memSlow = 1'b0;
	logic loadBusy, loadDone, loadFault, busReq, busWrite, busLock, busAck, accDone, accFault;
	logic [7:0] loadVector, accVector;
	logic [15:0] loadedSel, busWData, busRData;
	logic [1:0] loadedSeg;
	logic [23:0] busAddr, physAddr;
	logic [36:0] expQ [$];
	logic [15:0] lastSel = 16'h0000;
	logic [1:0] lastSeg = 2'h0;
	logic [23:0] lastPa = 24'h000000;
	int error_cnt = 0;
	int n_checks = 0;

	sdc_check sdc_check_i (.ref_clk(ref_clk), .reset(reset), .loadReq(loadReq), .loadSeg(loadSeg),
		.loadSel(loadSel), .globalTableBase(GBASE), .globalTableLimit(16'h001F), .localTableBase(LBASE),
		.localTableLimit(16'h000F), .loadBusy(loadBusy), .loadDone(loadDone), .loadFault(loadFault),
		.loadVector(loadVector), .loadedSel(loadedSel), .loadedSeg(loadedSeg), .busReq(busReq),
		.busWrite(busWrite), .busLock(busLock), .busAddr(busAddr), .busWData(busWData), .busRData(busRData),
		.busAck(busAck), .accReq(accReq), .accSeg(accSeg), .accOffset(accOffset), .accWrite(accWrite),
		.accExec(accExec), .current_priv_level(curLevel), .accDone(accDone), .accFault(accFault),
		.accVector(accVector), .physAddr(physAddr));
	sdc_mem_model sdc_mem_model_i (.ref_clk(ref_clk), .reset(reset), .slow(memSlow), .busReq(busReq),
		.busWrite(busWrite), .busLock(busLock), .busAddr(busAddr), .busWData(busWData),
		.busRData(busRData), .busAck(busAck));

	// free-running clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [36:0] got, input logic [36:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	function automatic logic [36:0] nextExp();
		if (expQ.size() == 0)
			return 37'h0;
		return expQ.pop_front();
	endfunction

	// compares every result pulse with the oldest note
	always @(negedge ref_clk) begin
		if (loadDone || loadFault)
			check({4'h1, loadFault, loadFault ? loadVector : 8'h00, 6'h00, loadedSeg, loadedSel},
				nextExp());
		if (accDone)
			check({4'h2, accFault, accFault ? accVector : 8'h00, physAddr},
				nextExp());
	end

	// places one 8-byte descriptor in memory as four words
	task automatic put(input logic [23:0] a, input logic [7:0] ac, input logic [23:0] b, input logic [15:0] lim);
		sdc_mem_model_i.mem[a[8:1]] = lim;
		sdc_mem_model_i.mem[a[8:1] + 8'h01] = b[15:0];
		sdc_mem_model_i.mem[a[8:1] + 8'h02] = {ac, b[23:16]};
		sdc_mem_model_i.mem[a[8:1] + 8'h03] = 16'h0000;
	endtask

	// one segment load; vec 0 means it must commit
	task automatic load(input logic [1:0] seg, input logic [15:0] sel, input logic [7:0] vec, input int acks);
		int a0;
		int n;
		logic [23:0] wa;
		a0 = sdc_mem_model_i.ackCnt;
		wa = (sel[2] ? LBASE : GBASE) + {8'h00, sel[15:3], 3'h4};
		@(posedge ref_clk);
		memSlow <= 1'($urandom % 2);
		loadReq <= 1'b1;
		loadSeg <= seg;
		loadSel <= sel;
		if (vec == 8'h00) begin
			lastSel = sel;
			lastSeg = seg;
		end
		expQ.push_back({4'h1, vec != 8'h00, vec, 6'h00, lastSeg, lastSel});
		@(posedge ref_clk);
		loadReq <= 1'b0;
		// busy only when the request passed the table bounds
		@(negedge ref_clk);
		check(37'(loadBusy), 37'(acks != 0));
		n = 0;
		while (!(loadDone || loadFault) && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		check(37'(sdc_mem_model_i.ackCnt - a0), 37'(acks));
		if (vec == 8'h00)
			check(37'(sdc_mem_model_i.mem[wa[8:1]][8]), 37'h1);
	endtask

	// one access check, issued back to back with the next call
	task automatic acc(input logic [1:0] seg, input logic [15:0] off, input logic wr, input logic ex,
		input logic [1:0] lvl, input logic [7:0] vec, input logic [23:0] pa);
		@(posedge ref_clk);
		accReq <= 1'b1;
		accSeg <= seg;
		accOffset <= off;
		accWrite <= wr;
		accExec <= ex;
		curLevel <= lvl;
		if (vec == 8'h00)
			lastPa = pa;
		expQ.push_back({4'h2, vec != 8'h00, vec, lastPa});
	endtask

	task automatic accIdle;
		@(posedge ref_clk);
		accReq <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// hang guard
	initial begin
		#200000;
		error_cnt++;
		$display("timeout reached");
		report_and_stop();
	end

	// main sequence
	initial begin
		logic [15:0] off;
		void'($urandom(45));
		put(GBASE, 8'h92, 24'h012340, 16'h00FF);
		put(GBASE + 24'h8, 8'hDC, 24'h0ABC00, 16'h0010);
		put(GBASE + 24'h10, 8'h12, 24'h055500, 16'h0FFF);
		put(GBASE + 24'h18, 8'h82, 24'h000200, 16'h00FF);
		put(LBASE, 8'h94, 24'h000100, 16'h0FFF);
		put(LBASE + 24'h8, 8'h9A, 24'hFFFF00, 16'hFFFF);
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		acc(2'h0, 16'h0000, 1'b0, 1'b0, 2'h0, EXC_NP, 24'h0);
		accIdle();
		$display("test unloaded done");
		load(2'h0, 16'h0000, 8'h00, 5);
		load(2'h1, 16'h000B, 8'h00, 5);
		load(2'h2, 16'h0004, 8'h00, 5);
		load(2'h3, 16'h000C, 8'h00, 5);
		load(2'h2, 16'h0010, EXC_NP, 4);
		load(2'h2, 16'h0018, EXC_GP, 4);
		load(2'h2, 16'h0020, EXC_GP, 0);
		load(2'h2, 16'h0014, EXC_GP, 0);
		$display("test loads done");
		acc(2'h0, 16'h00FF, 1'b0, 1'b0, 2'h0, 8'h00, 24'h01243F);
		acc(2'h0, 16'h0100, 1'b0, 1'b0, 2'h0, EXC_GP, 24'h0);
		acc(2'h0, 16'h0010, 1'b1, 1'b0, 2'h0, 8'h00, 24'h012350);
		acc(2'h0, 16'h0010, 1'b0, 1'b1, 2'h0, EXC_GP, 24'h0);
		acc(2'h1, 16'h0010, 1'b0, 1'b1, 2'h3, 8'h00, 24'h0ABC10);
		acc(2'h1, 16'h000F, 1'b0, 1'b1, 2'h2, 8'h00, 24'h0ABC0F);
		acc(2'h1, 16'h0010, 1'b0, 1'b1, 2'h1, EXC_GP, 24'h0);
		acc(2'h1, 16'h0011, 1'b0, 1'b1, 2'h3, EXC_GP, 24'h0);
		acc(2'h1, 16'h0000, 1'b0, 1'b0, 2'h3, EXC_GP, 24'h0);
		acc(2'h1, 16'h0000, 1'b1, 1'b0, 2'h3, EXC_GP, 24'h0);
		acc(2'h2, 16'h1000, 1'b0, 1'b0, 2'h0, 8'h00, 24'h001100);
		acc(2'h2, 16'h0FFF, 1'b0, 1'b0, 2'h0, EXC_GP, 24'h0);
		acc(2'h2, 16'h2000, 1'b1, 1'b0, 2'h0, EXC_GP, 24'h0);
		acc(2'h3, 16'h0100, 1'b0, 1'b0, 2'h0, 8'h00, 24'h000000);
		acc(2'h3, 16'h0100, 1'b1, 1'b0, 2'h0, EXC_GP, 24'h0);
		accIdle();
		$display("test access rights done");
		for (int i = 0; i < 8; i++) begin
			off = 16'($urandom % 256);
			acc(2'h0, off, 1'($urandom % 2), 1'b0, 2'($urandom % 4), 8'h00, 24'h012340 + {8'h00, off});
		end
		accIdle();
		$display("test random offsets done");
		check(37'(sdc_mem_model_i.lockMiss), 37'h0);
		check(37'(expQ.size()), 37'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
